// ---- hdl/ddrt_pkg.sv ----
// constants and types shared by the DDR timing-parameter control block
package ddrt_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMING_CFG_OFS = 8'h54;
  localparam logic [7:0] MODE_CTRL_OFS = 8'h58;

  // ----------------------------------------------------------------
  // timing configuration field positions
  // ----------------------------------------------------------------
  localparam int SUPER_BYPASS_WAIT_BIT = 31;
  localparam int CMD_BUS_COPY_A_DELAY_BIT = 30;
  localparam int CMD_BUS_COPY_B_DELAY_BIT = 29;
  localparam int READ_WAIT_BIT = 28;
  localparam int REGISTERED_MODULE_SELECT_BIT = 27;
  localparam int WRITE_TO_READ_DELAY_BIT = 26;
  localparam int WRITE_RECOVERY_TIME_LSB = 24;
  localparam int ACTIVATE_TO_ACTIVATE_OTHER_BANK_BIT = 23;
  localparam int IDLE_CYCLE_LIMIT_LSB = 16;
  localparam int PAGE_HIT_STREAK_CAP_LSB = 14;
  localparam int ROW_CYCLE_TIME_LSB = 9;
  localparam int PRECHARGE_TIME_LSB = 7;
  localparam int ROW_ACTIVE_TIME_LSB = 4;
  localparam int CAS_LATENCY_LSB = 2;
  localparam int ACTIVATE_TO_ACCESS_DELAY_LSB = 0;
  // reserved bits 22..19 and 13..12 read as zero
  localparam logic [31:0] TIMING_CFG_MASK = 32'hFF87CFFF;

  // mode/control register: init-start bit, write-one-to-set
  localparam int INIT_START_BIT = 25;
  localparam logic INIT_START_RESET = 1'b0;

  // ----------------------------------------------------------------
  // counter widths and special codes
  // ----------------------------------------------------------------
  localparam int GAP_W = 4;
  localparam int IDLE_W = 6;
  localparam int STREAK_W = 5;
  localparam logic [2:0] IDLE_DISABLE_CODE = 3'h7;

  // command kinds seen by the scheduler
  typedef enum logic [1:0] {CMD_ACT, CMD_RD, CMD_WR, CMD_PRE} ddrt_cmd_t;

endpackage : ddrt_pkg

// ---- hdl/ddrt_gap_cnt.sv ----
// saturating counter of clock cycles since the last event
`timescale 1ns/10ps
module ddrt_gap_cnt #(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hit,
  output logic [W-1:0] gap
);

  // reset to saturation so that no spacing is owed after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gap <= '1;
    end else if (hit) begin
      gap <= W'(1);
    end else if (gap != '1) begin
      gap <= gap + W'(1);
    end
  end

endmodule : ddrt_gap_cnt

// ---- hdl/ddrt_timing_ctl.sv ----
// DDR command timing scheduler with its timing configuration register
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps

// What this block does
// - The timing register has no reset value; it is undefined until written.
// - One programmed timing set applies to every bank.
// - Super-bypass wait bit adds one wait state on every super-bypass read.
// - Read wait bit adds one wait state before read data returns.
// - Bit 30 adds extra output delay on command bus copy A.
// - Bit 29 adds extra output delay on command bus copy B.
// - Bit 27 selects unbuffered (0) or registered (1) modules.
// - Keep 1 or 2 clocks from last write data to next read.
// - Write recovery before precharge of same bank: 1, 2 or 3 clocks.
// - Activates to different banks spaced 2 or 3 clocks apart.
// - Precharge an idle open bank after programmed idle cycles; 111 disables.
// - At most 1, 4, 8 or 16 consecutive page hits before a non-hit.
// - Activate to activate of same bank at least field plus three cycles.
// - Precharge to activate of same bank waits 3, 2, 1 or 4 cycles.
// - Activate to precharge of same bank at least field plus two cycles.
// - CAS latency is 3, 2 or 2.5 cycles; code 11 reserved.
// - Read or write follows its activate by 1, 2, 3 or 4 cycles.
// - Setting init start begins initialization; software cannot clear it.
module ddrt_timing_ctl #(
  parameter int NUM_BANKS = 4,
  parameter int BANK_W = 2,
  parameter int DATA_W = 64
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  input wire logic reqValid,
  input wire ddrt_pkg::ddrt_cmd_t reqKind,
  input wire logic [BANK_W-1:0] reqBank,
  input wire logic reqPageHit,
  input wire logic altReqPending,
  output logic reqReady,
  input wire logic wrDataLast,
  output logic cmdValid,
  output ddrt_pkg::ddrt_cmd_t cmdKind,
  output logic [BANK_W-1:0] cmdBank,
  output logic cmdCopyADelay,
  output logic cmdCopyBDelay,
  output logic registeredModule,
  output logic [3:0] casHalfCycles,
  output logic initStart,
  input wire logic memRdValid,
  input wire logic [DATA_W-1:0] memRdData,
  output logic rdRetValid,
  output logic [DATA_W-1:0] rdRetData,
  input wire logic sbpRdValid,
  input wire logic [DATA_W-1:0] sbpRdData,
  output logic sbpRetValid,
  output logic [DATA_W-1:0] sbpRetData
);

  localparam int IDLE_W_L = ddrt_pkg::IDLE_W;
  localparam int GW = ddrt_pkg::GAP_W;

  // ----------------------------------------------------------------
  // field decoders
  // ----------------------------------------------------------------
  // reserved write-recovery code 01 is treated as the longest, 3 clocks
  function automatic logic [3:0] wrRecMin(input logic [1:0] code);
    unique case (code)
      2'b00: wrRecMin = 4'h1;
      2'b10: wrRecMin = 4'h2;
      default: wrRecMin = 4'h3;
    endcase
  endfunction : wrRecMin

  function automatic logic [3:0] rpMin(input logic [1:0] code);
    unique case (code)
      2'b00: rpMin = 4'h3;
      2'b01: rpMin = 4'h2;
      2'b10: rpMin = 4'h1;
      default: rpMin = 4'h4;
    endcase
  endfunction : rpMin

  function automatic logic [IDLE_W_L-1:0] idleLimit(input logic [2:0] code);
    unique case (code)
      3'h0: idleLimit = 6'h00;
      3'h1: idleLimit = 6'h08;
      3'h2: idleLimit = 6'h0C;
      3'h3: idleLimit = 6'h10;
      3'h4: idleLimit = 6'h18;
      3'h5: idleLimit = 6'h20;
      default: idleLimit = 6'h30;
    endcase
  endfunction : idleLimit

  function automatic logic [4:0] phCap(input logic [1:0] code);
    unique case (code)
      2'b00: phCap = 5'h01;
      2'b01: phCap = 5'h04;
      2'b10: phCap = 5'h08;
      default: phCap = 5'h10;
    endcase
  endfunction : phCap

  // latency in half clocks; reserved 11 falls back to the slowest, 3 clocks
  function automatic logic [3:0] casHalf(input logic [1:0] code);
    unique case (code)
      2'b01: casHalf = 4'h4;
      2'b10: casHalf = 4'h5;
      default: casHalf = 4'h6;
    endcase
  endfunction : casHalf

  logic [31:0] cfg_r;
  logic initStart_r;
  logic pend_r;
  ddrt_pkg::ddrt_cmd_t pendKind_r;
  logic [BANK_W-1:0] pendBank_r;
  logic pendPh_r;
  logic [NUM_BANKS-1:0] bankOpen_r;
  logic [IDLE_W_L-1:0] idleCnt_r;
  logic [ddrt_pkg::STREAK_W-1:0] streak_r;
  logic memRd1Valid_r;
  logic [DATA_W-1:0] memRd1Data_r;
  logic sbpRd1Valid_r;
  logic [DATA_W-1:0] sbpRd1Data_r;
  logic [GW-1:0] actGap [NUM_BANKS];
  logic [GW-1:0] rpGap [NUM_BANKS];
  logic [GW-1:0] wrGap [NUM_BANKS];
  logic [GW-1:0] actAllGap;
  logic [GW-1:0] wtrGap;
  logic [NUM_BANKS-1:0] preOk;
  logic [3:0] rcMinV, rasMinV, rcdMinV, rrdMinV, wtrMinV, wrMinV, rpMinV;
  logic [2:0] idleCode;
  logic timingOk, phHold, issueReq, idleHit, issueIdle, issueNow, reqTake;
  logic [BANK_W-1:0] idleBank, issueBank;
  ddrt_pkg::ddrt_cmd_t issueKind;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // no reset on purpose: contents stay unknown until software writes them
  always_ff @(posedge ref_clk) begin
    if (regWrStb && regAddr == ddrt_pkg::TIMING_CFG_OFS) begin
      cfg_r <= regWrData & ddrt_pkg::TIMING_CFG_MASK;
    end
  end

  // write-one-to-set; writing zero never clears it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      initStart_r <= ddrt_pkg::INIT_START_RESET;
    end else if (regWrStb && regAddr == ddrt_pkg::MODE_CTRL_OFS &&
                 regWrData[ddrt_pkg::INIT_START_BIT]) begin
      initStart_r <= 1'b1;
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !regRdStb) begin
      regRdData <= 32'h0000_0000;
    end else if (regAddr == ddrt_pkg::TIMING_CFG_OFS) begin
      regRdData <= cfg_r;
    end else if (regAddr == ddrt_pkg::MODE_CTRL_OFS) begin
      regRdData <= {6'h00, initStart_r, 25'h0000000};
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // decoded minimum spacings, shared by all banks
  // ----------------------------------------------------------------
  always_comb begin
    rcMinV = 4'(cfg_r[ddrt_pkg::ROW_CYCLE_TIME_LSB +: 3]) + 4'h3;
    rasMinV = 4'(cfg_r[ddrt_pkg::ROW_ACTIVE_TIME_LSB +: 3]) + 4'h2;
    rcdMinV = 4'(cfg_r[ddrt_pkg::ACTIVATE_TO_ACCESS_DELAY_LSB +: 2]) + 4'h1;
    rrdMinV = cfg_r[ddrt_pkg::ACTIVATE_TO_ACTIVATE_OTHER_BANK_BIT] ? 4'h3 : 4'h2;
    wtrMinV = cfg_r[ddrt_pkg::WRITE_TO_READ_DELAY_BIT] ? 4'h2 : 4'h1;
    wrMinV = wrRecMin(cfg_r[ddrt_pkg::WRITE_RECOVERY_TIME_LSB +: 2]);
    rpMinV = rpMin(cfg_r[ddrt_pkg::PRECHARGE_TIME_LSB +: 2]);
    idleCode = cfg_r[ddrt_pkg::IDLE_CYCLE_LIMIT_LSB +: 3];
  end

  // ----------------------------------------------------------------
  // per-bank spacing counters
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic actHit, preHit, wrHit;
      assign actHit = issueNow && issueKind == ddrt_pkg::CMD_ACT && issueBank == BANK_W'(b);
      assign preHit = issueNow && issueKind == ddrt_pkg::CMD_PRE && issueBank == BANK_W'(b);
      assign wrHit = issueNow && issueKind == ddrt_pkg::CMD_WR && issueBank == BANK_W'(b);
      // same decoded minimums for every bank
      assign preOk[b] = actGap[b] >= rasMinV && wrGap[b] >= wrMinV;
      ddrt_gap_cnt #(.W(GW)) u_act (.ref_clk(ref_clk), .rst_n(rst_n), .hit(actHit),
        .gap(actGap[b]));
      ddrt_gap_cnt #(.W(GW)) u_pre (.ref_clk(ref_clk), .rst_n(rst_n), .hit(preHit),
        .gap(rpGap[b]));
      ddrt_gap_cnt #(.W(GW)) u_wr (.ref_clk(ref_clk), .rst_n(rst_n), .hit(wrHit),
        .gap(wrGap[b]));
      // open-row tracking
      always_ff @(posedge ref_clk) begin
        if (!rst_n || preHit) begin
          bankOpen_r[b] <= 1'b0;
        end else if (actHit) begin
          bankOpen_r[b] <= 1'b1;
        end
      end
    end
  endgenerate

  // any-bank activate spacing and write-data-to-read spacing
  ddrt_gap_cnt #(.W(GW)) u_act_all (.ref_clk(ref_clk), .rst_n(rst_n),
    .hit(issueNow && issueKind == ddrt_pkg::CMD_ACT), .gap(actAllGap));
  ddrt_gap_cnt #(.W(GW)) u_wtr (.ref_clk(ref_clk), .rst_n(rst_n), .hit(wrDataLast),
    .gap(wtrGap));

  // ----------------------------------------------------------------
  // issue decision
  // ----------------------------------------------------------------
  // pending command waits until every spacing is met
  always_comb begin
    unique case (pendKind_r)
      ddrt_pkg::CMD_ACT: timingOk = !bankOpen_r[pendBank_r] && actGap[pendBank_r] >= rcMinV &&
        rpGap[pendBank_r] >= rpMinV && actAllGap >= rrdMinV;
      ddrt_pkg::CMD_RD: timingOk = bankOpen_r[pendBank_r] && actGap[pendBank_r] >= rcdMinV &&
        wtrGap >= wtrMinV;
      ddrt_pkg::CMD_WR: timingOk = bankOpen_r[pendBank_r] && actGap[pendBank_r] >= rcdMinV;
      ddrt_pkg::CMD_PRE: timingOk = preOk[pendBank_r];
    endcase
  end

  // page hits yield once the streak reaches the cap and a miss waits
  assign phHold = pendPh_r && altReqPending &&
    streak_r >= phCap(cfg_r[ddrt_pkg::PAGE_HIT_STREAK_CAP_LSB +: 2]);
  // nothing reaches the memory before software has started initialization
  assign issueReq = initStart_r && pend_r && timingOk && !phHold;

  // lowest-numbered open bank is the idle precharge victim
  always_comb begin
    idleBank = '0;
    for (int i = NUM_BANKS - 1; i >= 0; i--) begin
      if (bankOpen_r[i]) begin
        idleBank = BANK_W'(i);
      end
    end
  end

  assign idleHit = initStart_r && !pend_r && !reqValid && idleCode != ddrt_pkg::IDLE_DISABLE_CODE &&
    idleCnt_r >= idleLimit(idleCode) && |bankOpen_r;
  assign issueIdle = idleHit && preOk[idleBank];
  assign issueNow = issueReq || issueIdle;
  assign issueKind = issueReq ? pendKind_r : ddrt_pkg::CMD_PRE;
  assign issueBank = issueReq ? pendBank_r : idleBank;
  assign reqTake = reqValid && reqReady;

  // one-deep holding stage; ready is registered so it trails issue by a cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      reqReady <= 1'b0;
    end else begin
      pend_r <= reqTake || (pend_r && !issueReq);
      reqReady <= !(reqTake || (pend_r && !issueReq));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pendKind_r <= ddrt_pkg::CMD_ACT;
      pendBank_r <= '0;
      pendPh_r <= 1'b0;
    end else if (reqTake) begin
      pendKind_r <= reqKind;
      pendBank_r <= reqBank;
      pendPh_r <= reqPageHit;
    end
  end

  // idle cycles: no valid request presented and none held
  always_ff @(posedge ref_clk) begin
    if (!rst_n || reqValid || pend_r || issueIdle) begin
      idleCnt_r <= '0;
    end else if (idleCnt_r != '1) begin
      idleCnt_r <= idleCnt_r + IDLE_W_L'(1);
    end
  end

  // consecutive page-hit streak
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      streak_r <= '0;
    end else if (issueReq) begin
      if (!pendPh_r) begin
        streak_r <= '0;
      end else if (streak_r != '1) begin
        streak_r <= streak_r + ddrt_pkg::STREAK_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // command and pad-control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmdValid <= 1'b0;
      cmdKind <= ddrt_pkg::CMD_ACT;
      cmdBank <= '0;
    end else begin
      cmdValid <= issueNow;
      cmdKind <= issueKind;
      cmdBank <= issueBank;
    end
  end

  // static settings follow the configuration; zero until the first clock after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmdCopyADelay <= 1'b0;
      cmdCopyBDelay <= 1'b0;
      registeredModule <= 1'b0;
      casHalfCycles <= 4'h0;
    end else begin
      cmdCopyADelay <= cfg_r[ddrt_pkg::CMD_BUS_COPY_A_DELAY_BIT];
      cmdCopyBDelay <= cfg_r[ddrt_pkg::CMD_BUS_COPY_B_DELAY_BIT];
      registeredModule <= cfg_r[ddrt_pkg::REGISTERED_MODULE_SELECT_BIT];
      casHalfCycles <= casHalf(cfg_r[ddrt_pkg::CAS_LATENCY_LSB +: 2]);
    end
  end

  assign initStart = initStart_r;

  // ----------------------------------------------------------------
  // read return with optional wait state
  // ----------------------------------------------------------------
  // the extra stage is always loaded; the wait bit picks which stage drives out
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      memRd1Valid_r <= 1'b0;
      sbpRd1Valid_r <= 1'b0;
      rdRetValid <= 1'b0;
      sbpRetValid <= 1'b0;
    end else begin
      memRd1Valid_r <= memRdValid;
      sbpRd1Valid_r <= sbpRdValid;
      rdRetValid <= cfg_r[ddrt_pkg::READ_WAIT_BIT] ? memRd1Valid_r : memRdValid;
      sbpRetValid <= cfg_r[ddrt_pkg::SUPER_BYPASS_WAIT_BIT] ? sbpRd1Valid_r : sbpRdValid;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      memRd1Data_r <= '0;
      sbpRd1Data_r <= '0;
      rdRetData <= '0;
      sbpRetData <= '0;
    end else begin
      memRd1Data_r <= memRdData;
      sbpRd1Data_r <= sbpRdData;
      rdRetData <= cfg_r[ddrt_pkg::READ_WAIT_BIT] ? memRd1Data_r : memRdData;
      sbpRetData <= cfg_r[ddrt_pkg::SUPER_BYPASS_WAIT_BIT] ? sbpRd1Data_r : sbpRdData;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_act;
    issueNow && issueKind == ddrt_pkg::CMD_ACT;
  endsequence
  sequence s_access;
    issueNow && (issueKind == ddrt_pkg::CMD_RD || issueKind == ddrt_pkg::CMD_WR);
  endsequence
  sequence s_pre_open;
    issueNow && issueKind == ddrt_pkg::CMD_PRE && bankOpen_r[issueBank];
  endsequence

  property p_rd_wait;
    memRdValid && cfg_r[ddrt_pkg::READ_WAIT_BIT] && $stable(cfg_r) |->
      ##2 rdRetValid && rdRetData == $past(memRdData, 2);
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state missing");
  property p_sbp_wait;
    sbpRdValid && !cfg_r[ddrt_pkg::SUPER_BYPASS_WAIT_BIT] |-> ##1 sbpRetValid;
  endproperty
  a_sbp_wait: assert property (p_sbp_wait) else $error("super-bypass read delayed");
  property p_init_sticky;
    initStart_r |=> initStart_r;
  endproperty
  a_init_sticky: assert property (p_init_sticky) else $error("init start cleared");
  property p_rrd;
    s_act ##0 cfg_r[ddrt_pkg::ACTIVATE_TO_ACTIVATE_OTHER_BANK_BIT] |=>
      (!(issueNow && issueKind == ddrt_pkg::CMD_ACT))[*2];
  endproperty
  a_rrd: assert property (p_rrd) else $error("activates too close");
  property p_rc;
    s_act |-> actGap[issueBank] >= rcMinV && rpGap[issueBank] >= rpMinV;
  endproperty
  a_rc: assert property (p_rc) else $error("activate too early for bank");
  property p_rcd;
    s_access |-> actGap[issueBank] >= rcdMinV;
  endproperty
  a_rcd: assert property (p_rcd) else $error("access too soon after activate");
  property p_wtr;
    issueNow && issueKind == ddrt_pkg::CMD_RD |-> wtrGap >= wtrMinV;
  endproperty
  a_wtr: assert property (p_wtr) else $error("read too soon after write data");
  property p_ras_wr;
    s_pre_open |-> actGap[issueBank] >= rasMinV && wrGap[issueBank] >= wrMinV;
  endproperty
  a_ras_wr: assert property (p_ras_wr) else $error("precharge too early");
  property p_cas;
    cfg_r[ddrt_pkg::CAS_LATENCY_LSB +: 2] == 2'b10 |=> casHalfCycles == 4'h5;
  endproperty
  a_cas: assert property (p_cas) else $error("cas latency 2.5 not applied");
  property p_idle;
    issueIdle |-> idleCode != ddrt_pkg::IDLE_DISABLE_CODE && idleCnt_r >= idleLimit(idleCode);
  endproperty
  a_idle: assert property (p_idle) else $error("idle precharge too early");
  // checked only after a write: the unwritten register is unknown on purpose
  property p_pads;
    regWrStb && regAddr == ddrt_pkg::TIMING_CFG_OFS |=> ##1
      cmdCopyADelay == $past(cfg_r[ddrt_pkg::CMD_BUS_COPY_A_DELAY_BIT]) &&
      cmdCopyBDelay == $past(cfg_r[ddrt_pkg::CMD_BUS_COPY_B_DELAY_BIT]) &&
      registeredModule == $past(cfg_r[ddrt_pkg::REGISTERED_MODULE_SELECT_BIT]);
  endproperty
  a_pads: assert property (p_pads) else $error("pad controls not following config");

endmodule : ddrt_timing_ctl

// ---- testbench/ddrt_mem_model.sv ----
// behavioural DIMM answering read commands for the timing bench
`timescale 1ns/10ps
module ddrt_mem_model (
  input wire logic ref_clk,
  input wire logic cmdValid,
  input wire ddrt_pkg::ddrt_cmd_t cmdKind,
  input wire logic [3:0] casHalfCycles,
  output logic memRdValid,
  output logic [63:0] memRdData
);
  int cnt = 0;
  logic [63:0] pat = 64'h0123456789ABCDEF;
  initial begin
    memRdValid = 1'b0;
    memRdData = 64'h0;
  end
  // read data after the programmed latency; idle bus toggles so stale data never matches
  always @(posedge ref_clk) begin
    if (cmdValid === 1'b1 && cmdKind == ddrt_pkg::CMD_RD) begin
      cnt <= (casHalfCycles + 1) / 2;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    memRdValid <= (cnt == 1);
    memRdData <= (cnt == 1) ? pat : ~memRdData;
    pat <= pat + 64'h1;
  end
endmodule : ddrt_mem_model

// ---- testbench/test_ddrt_timing_ctl.sv ----
// self-checking bench for the DDR timing-parameter control block
`timescale 1ns/10ps
module test_ddrt_timing_ctl;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [3:0] cas;} ddrt_row_t;
  localparam logic [31:0] BASE = 32'h1787CFF7;
  logic ref_clk, rst_n, regWrStb, regRdStb, reqValid, reqPageHit, altReqPending, wrDataLast;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, d;
  ddrt_pkg::ddrt_cmd_t reqKind, cmdKind;
  logic [1:0] reqBank, cmdBank;
  logic reqReady, cmdValid, cmdCopyADelay, cmdCopyBDelay, registeredModule, initStart;
  logic [3:0] casHalfCycles;
  logic memRdValid, rdRetValid, sbpRdValid, sbpRetValid;
  logic [63:0] memRdData, rdRetData, sbpRdData, sbpRetData, memD;
  int fails = 0, tests_run = 0, cyc = 0, nCmd = 0, memT = 0, sbpT = 0, rdD = 1, sbpD = 1;
  int ts[16];
  ddrt_pkg::ddrt_cmd_t ks[16];
  logic [1:0] bs[16];
  ddrt_row_t rows[6] = '{
    '{ddrt_pkg::TIMING_CFG_OFS, 32'hFFFFFFFF, 32'hFF87CFFF, 4'h6},
    '{ddrt_pkg::TIMING_CFG_OFS, 32'h40000000, 32'h40000000, 4'h6},
    '{ddrt_pkg::TIMING_CFG_OFS, 32'h20000004, 32'h20000004, 4'h4},
    '{ddrt_pkg::TIMING_CFG_OFS, 32'h08000008, 32'h08000008, 4'h5},
    '{8'h10, 32'hFFFFFFFF, 32'h0, 4'h0},
    '{ddrt_pkg::MODE_CTRL_OFS, 32'h0, 32'h0, 4'h0}};
  ddrt_pkg::ddrt_cmd_t sk[5] = '{ddrt_pkg::CMD_ACT, ddrt_pkg::CMD_ACT, ddrt_pkg::CMD_RD,
    ddrt_pkg::CMD_PRE, ddrt_pkg::CMD_ACT};
  logic [1:0] sb[5] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1};
  int sd[5] = '{0, 3, 4, 5, 4};
  ddrt_pkg::ddrt_cmd_t sk2[4] = '{ddrt_pkg::CMD_ACT, ddrt_pkg::CMD_WR, ddrt_pkg::CMD_PRE,
    ddrt_pkg::CMD_ACT};
  int sd2[4] = '{0, 4, 3, 3};

  ddrt_timing_ctl DUT (.ref_clk, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .reqValid, .reqKind, .reqBank, .reqPageHit, .altReqPending, .reqReady,
    .wrDataLast, .cmdValid, .cmdKind, .cmdBank, .cmdCopyADelay, .cmdCopyBDelay,
    .registeredModule, .casHalfCycles, .initStart, .memRdValid, .memRdData, .rdRetValid,
    .rdRetData, .sbpRdValid, .sbpRdData, .sbpRetValid, .sbpRetData);
  ddrt_mem_model MEM (.ref_clk, .cmdValid, .cmdKind, .casHalfCycles, .memRdValid,
    .memRdData);

  // ----------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // whole run needs under two hundred cycles; this cuts a hang short
  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
  task automatic end_of_test();
    $display("checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask : check
  task automatic regWr(input logic [7:0] a, input logic [31:0] w);
    @(posedge ref_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= w;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask : regWr
  task automatic regRd(input logic [7:0] a, output logic [31:0] q);
    @(posedge ref_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    // read data stands in the cycle after the strobe; take it at its closing edge
    @(posedge ref_clk);
    q = regRdData;
  endtask : regRd
  // request held until the edge that takes it
  task automatic req(input ddrt_pkg::ddrt_cmd_t k, input logic [1:0] b);
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqKind <= k;
    reqBank <= b;
    do @(posedge ref_clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
  endtask : req
  task automatic waitCmd(input int n);
    for (int i = 0; i < 60 && nCmd < n; i++) @(negedge ref_clk);
  endtask : waitCmd
  task automatic sbpPulse();
    @(posedge ref_clk);
    sbpRdValid <= 1'b1;
    @(posedge ref_clk);
    sbpRdValid <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : sbpPulse

  // monitor: issue log and read-return latency, counted in cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cmdValid === 1'b1 && nCmd < 16) begin
      ts[nCmd] = cyc;
      ks[nCmd] = cmdKind;
      bs[nCmd] = cmdBank;
      nCmd++;
    end
    if (rdRetValid === 1'b1) begin
      check("rdRetDelay", cyc - memT, rdD);
      check("rdRetData", rdRetData, memD);
    end
    if (sbpRetValid === 1'b1) begin
      check("sbpRetDelay", cyc - sbpT, sbpD);
      check("sbpRetData", sbpRetData, sbpRdData);
    end
    if (memRdValid === 1'b1) begin
      memT = cyc;
      memD = memRdData;
    end
    if (sbpRdValid === 1'b1) sbpT = cyc;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {regWrStb, regRdStb, reqValid, reqPageHit, altReqPending, wrDataLast, sbpRdValid} = 7'h0;
    regAddr = 8'h0;
    regWrData = 32'h0;
    reqKind = ddrt_pkg::CMD_ACT;
    reqBank = 2'h0;
    sbpRdData = 64'h00000000CAFE0001;
    repeat (20) @(posedge ref_clk);
    check("resetOutputs", {cmdValid, reqReady, initStart, rdRetValid, sbpRetValid}, 5'h0);
    rst_n <= 1'b1;
    // register rows: read-back and derived outputs
    foreach (rows[i]) begin
      regWr(rows[i].a, rows[i].w);
      regRd(rows[i].a, d);
      check("regRdData", d, rows[i].r);
      if (rows[i].a == ddrt_pkg::TIMING_CFG_OFS) begin
        check("casHalfCycles", casHalfCycles, rows[i].cas);
        check("cmdCopyADelay", cmdCopyADelay, rows[i].r[30]);
        check("cmdCopyBDelay", cmdCopyBDelay, rows[i].r[29]);
        check("registeredModule", registeredModule, rows[i].r[27]);
      end
    end
    // software programs timing before init start
    regWr(ddrt_pkg::TIMING_CFG_OFS, BASE);
    rdD = 2;
    req(ddrt_pkg::CMD_ACT, 2'h0);
    repeat (10) @(posedge ref_clk);
    check("issueBeforeInit", nCmd, 0);
    regWr(ddrt_pkg::MODE_CTRL_OFS, 32'h02000000);
    for (int i = 1; i < 5; i++) req(sk[i], sb[i]);
    waitCmd(5);
    for (int i = 0; i < 5; i++) begin
      check("cmdKind", ks[i], sk[i]);
      check("cmdBank", bs[i], sb[i]);
      if (i > 0) check("cmdGap", ts[i] - ts[i - 1], sd[i]);
    end
    // init start cannot be cleared; idle precharge off with code 111
    regWr(ddrt_pkg::MODE_CTRL_OFS, 32'h0);
    regRd(ddrt_pkg::MODE_CTRL_OFS, d);
    check("initStart", d, 32'h02000000);
    check("initStartPin", initStart, 1'b1);
    repeat (20) @(posedge ref_clk);
    check("idleDisabled", nCmd, 5);
    sbpPulse();
    regWr(ddrt_pkg::TIMING_CFG_OFS, BASE | 32'h80000000);
    sbpD = 2;
    sbpPulse();
    // idle limit of 8 cycles: lowest open bank gets precharged
    regWr(ddrt_pkg::TIMING_CFG_OFS, (BASE & 32'hFFF8FFFF) | 32'h00010000);
    waitCmd(6);
    check("idleKind", ks[5], ddrt_pkg::CMD_PRE);
    check("idleBank", bs[5], 2'h0);
    // bank 2 cycle with short active and precharge times: write recovery and row cycle bind
    regWr(ddrt_pkg::TIMING_CFG_OFS, 32'h1787CF07);
    foreach (sk2[i]) req(sk2[i], 2'h2);
    waitCmd(10);
    for (int i = 6; i < 10; i++) begin
      check("cmd2Kind", ks[i], sk2[i - 6]);
      check("cmd2Bank", bs[i], 2'h2);
      if (i > 6) check("cmd2Gap", ts[i] - ts[i - 1], sd2[i - 6]);
    end
    end_of_test();
  end
endmodule : test_ddrt_timing_ctl
